// file: dv/adcri_analog_model.sv
// Analog front end stand-in: eight held input levels and a comparator.
// Assumes the converter drives the trial code and channel select directly.
`timescale 1ns/1ps
`default_nettype none
module adcri_analog_model
(
    input  wire logic [79:0] levels,          // Ten-bit level per input
    input  wire logic [9:0]  dac_code,        // Trial code
    input  wire logic [2:0]  conv_channel,    // Selected input
    output logic             comparator_high  // Input at or above trial
);
    // ==========================================================
    // Comparator
    // Level sits half an LSB above its code, so equality keeps the bit
    assign comparator_high = levels[conv_channel * 10 +: 10] >= dac_code;
endmodule
`default_nettype wire

// file: dv/adcri_top_assertions.sv
// Concurrent checks on the converter register interface.
// Bound to adcri_top by the bench; sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module adcri_top_assertions
(
    input  wire logic                          pclk,               // Clock
    input  wire logic                          presetn,            // Reset, active low
    input  wire logic                          psel,               // APB select
    input  wire logic                          penable,            // APB access
    input  wire logic                          pwrite,             // APB direction
    input  wire logic [31:0]                   paddr,              // APB address
    input  wire logic [31:0]                   prdata,             // APB read data
    input  wire logic                          pslverr,            // APB error
    input  wire logic                          standby,            // Standby request
    input  wire logic [adcri_pkg::RES_BITS-1:0] dac_code,          // Trial code
    input  wire logic [2:0]                    conv_channel,       // Channel
    input  wire logic                          conv_active,        // Converting
    input  wire logic                          conversion_end_irq, // Interrupt
    input  wire logic                          dma_request         // Done flag
);
    import adcri_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [29:0] idx;
    logic        acc;
    logic        hit;
    assign idx = paddr[31:2] & IDX_DEC_MASK;
    assign acc = psel && penable;
    assign hit = idx >= (IDX_RES_A_HIGH & IDX_DEC_MASK) && idx <= (IDX_TRIG_CTRL & IDX_DEC_MASK);
    // ==========================================================
    // Bus side
    property p_unmapped; acc && !hit |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped; acc && hit |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_low_zero;
        acc && !pwrite && hit && idx[0] && idx < (IDX_CTRL_STAT & IDX_DEC_MASK)
            |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low byte reserved bits set");
    // ==========================================================
    // Conversion side
    property p_dac_start; $rose(conv_active) |-> dac_code == 10'h200; endproperty
    a_dac_start: assert property (p_dac_start) else $error("first trial code wrong");
    property p_group; conv_active && $past(conv_active) |-> conv_channel[2] == $past(conv_channel[2]); endproperty
    a_group: assert property (p_group) else $error("channel left its group");
    property p_scan_step;
        conv_active && $past(conv_active) && conv_channel != $past(conv_channel)
            |-> conv_channel[1:0] == $past(conv_channel[1:0]) + 2'd1 || conv_channel[1:0] == 2'd0;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan order wrong");
    property p_done_set; $rose(dma_request) |-> $past(conv_active) || $past(conv_active, 2); endproperty
    a_done_set: assert property (p_done_set) else $error("done set without conversion");
    property p_irq; conversion_end_irq |-> dma_request; endproperty
    a_irq: assert property (p_irq) else $error("interrupt without done");
    property p_standby; standby && $past(standby) |-> !conv_active && !dma_request; endproperty
    a_standby: assert property (p_standby) else $error("standby did not clear");
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench: APB master, trigger pin, standby, DMA flag, analog model.
// Assumes adcri_pkg and adcri_top compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcri_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        standby = 1'b0;
    logic        ext = 1'b1;
    logic        dma_access = 1'b0;
    logic [79:0] levels = 80'h0;
    logic        pready, pslverr, cmp, conv_active, irq, dreq;
    logic [31:0] prdata;
    logic [9:0]  dac_code;
    logic [2:0]  conv_channel;
    int          err_count = 0;
    int          checks_done = 0;
    always #4 pclk = ~pclk;
    adcri_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .standby(standby), .external_start_input(ext), .comparator_high(cmp), .dma_access(dma_access),
        .dac_code(dac_code), .conv_channel(conv_channel), .conv_active(conv_active),
        .conversion_end_irq(irq), .dma_request(dreq));
    adcri_analog_model u_ana (.levels(levels), .dac_code(dac_code), .conv_channel(conv_channel),
        .comparator_high(cmp));
    // ==========================================================
    // Helpers
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [29:0] ix, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {ix, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle cycle keeps each strobe to one assignment per time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [29:0] ix, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, ix, wd, d, e);
    endtask
    task automatic rd(input logic [29:0] ix, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic        e;
        apb(1'b0, ix, 8'h00, d, e);
        chk(nm, exp, d);
    endtask
    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (dreq !== 1'b1 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim)
        begin
            err_count++;
            print_verdict();
        end
    endtask
    function automatic logic [31:0] hi_exp(input logic [9:0] v);
        return {24'h0, v[9:2]};
    endfunction
    function automatic logic [31:0] lo_exp(input logic [9:0] v);
        return {24'h0, v[1:0], 6'h00};
    endfunction
    function automatic logic [29:0] slot(input int ch);
        return IDX_RES_A_HIGH + 30'(2 * (ch % 4));
    endfunction
    // ==========================================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic        e;
        logic [9:0]  v;
        logic [7:0]  c;
        int          n;
        void'($urandom(32'h085ff43f));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++)
            rd(IDX_RES_A_HIGH + 30'(i), (i == 9) ? {24'h0, TRG_RESET} : 32'h0, "reset value");
        apb(1'b0, IDX_TRIG_CTRL + 30'h1, 8'h00, d, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        rd(IDX_TRIG_CTRL ^ 30'h00fffe00, {24'h0, TRG_RESET}, "alias read");
        // Every channel once, code extremes first and last
        for (int k = 0; k < 8; k++)
        begin
            v = (k == 0) ? 10'h000 : (k == 7) ? 10'h3ff : 10'($urandom);
            levels[k*10 +: 10] <= v;
            c = 8'h28 | 8'(k) | (k[0] ? 8'h40 : 8'h00);
            wr(IDX_CTRL_STAT, c);
            wait_done(2000, n);
            chk("conv cycles", 32'h1, {31'h0, (n + 1) <= int'(CONV_CYCLES)});
            chk("irq", {31'h0, k[0]}, {31'h0, irq});
            rd(IDX_CTRL_STAT, {24'h0, (c | 8'h80) & 8'hdf}, "csr done");
            wr(slot(k), 8'hff);
            dma_access <= (k == 3);
            rd(slot(k) ^ 30'h00fffe00, hi_exp(v), "result high");
            dma_access <= 1'b0;
            rd(slot(k) + 30'h1, lo_exp(v), "result low");
            rd(IDX_CTRL_STAT, {24'h0, ((k == 3) ? 8'h00 : 8'h80) | (c & 8'hdf)}, "dma clear");
            wr(IDX_CTRL_STAT, 8'h00);
        end
        wr(IDX_CTRL_STAT, 8'h80);
        rd(IDX_CTRL_STAT, 32'h0, "done by write");
        rd(IDX_RES_A_LOW, lo_exp(v), "latch only");
        ext <= 1'b0;
        repeat (3) @(posedge pclk);
        ext <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("trigger disabled", 32'h0, {31'h0, conv_active});
        wr(IDX_TRIG_CTRL, 8'h80);
        // Slow conversion time, started from the pin
        wr(IDX_CTRL_STAT, 8'h02);
        ext <= 1'b0;
        wait_done(2000, n);
        chk("slow cycles", 32'h1, {31'h0, n > int'(CONV_CYCLES) && n <= 2 * int'(CONV_CYCLES)});
        rd(slot(2), hi_exp(levels[20 +: 10]), "trigger result");
        rd(IDX_CTRL_STAT, 32'h82, "trigger csr");
        wr(IDX_CTRL_STAT, 8'h82);
        rd(IDX_CTRL_STAT, 32'h82, "done kept");
        wr(IDX_CTRL_STAT, 8'h00);
        for (int i = 4; i < 7; i++)
            levels[i*10 +: 10] <= 10'($urandom);
        wr(IDX_CTRL_STAT, 8'h3e);
        wait_done(4000, n);
        repeat (5) @(posedge pclk);
        chk("scan runs on", 32'h1, {31'h0, conv_active});
        for (int i = 4; i < 7; i++)
            rd(slot(i), hi_exp(levels[i*10 +: 10]), "scan result");
        wr(IDX_CTRL_STAT, 8'h1e);
        @(posedge pclk);
        chk("scan stop", 32'h0, {31'h0, conv_active});
        wr(IDX_CTRL_STAT, 8'h3e);
        standby <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("standby stop", 32'h0, {31'h0, conv_active});
        standby <= 1'b0;
        @(posedge pclk);
        rd(slot(4), 32'h0, "standby result");
        rd(IDX_CTRL_STAT, 32'h0, "standby csr");
        print_verdict();
    end
endmodule
bind adcri_top adcri_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .standby(standby),
    .dac_code(dac_code), .conv_channel(conv_channel), .conv_active(conv_active),
    .conversion_end_irq(conversion_end_irq), .dma_request(dma_request));
`default_nettype wire

// file: rtl/adcri_pkg.sv
// Shared constants and types for the converter register interface.
// Assumes a 125 MHz pclk; all counts are derived here from printed times.
package adcri_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CONV_TIME_NS  = 6700;
    localparam int unsigned RES_BITS      = 10;
    // Longest time rounds down: 837 cycles for a full channel
    localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned BIT_CYCLES    = CONV_CYCLES / RES_BITS;
    localparam int unsigned SLOW_FACTOR   = 2;
    localparam int unsigned STEP_W        = 9;
    localparam logic [STEP_W-1:0] STEP_FAST = STEP_W'(BIT_CYCLES - 1);
    localparam logic [STEP_W-1:0] STEP_SLOW = STEP_W'(BIT_CYCLES * SLOW_FACTOR - 1);

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [29:0] IDX_RES_A_HIGH = 30'h05fffee0;
    localparam logic [29:0] IDX_RES_A_LOW  = 30'h05fffee1;
    localparam logic [29:0] IDX_RES_B_HIGH = 30'h05fffee2;
    localparam logic [29:0] IDX_RES_B_LOW  = 30'h05fffee3;
    localparam logic [29:0] IDX_RES_C_HIGH = 30'h05fffee4;
    localparam logic [29:0] IDX_RES_C_LOW  = 30'h05fffee5;
    localparam logic [29:0] IDX_RES_D_HIGH = 30'h05fffee6;
    localparam logic [29:0] IDX_RES_D_LOW  = 30'h05fffee7;
    localparam logic [29:0] IDX_CTRL_STAT  = 30'h05fffee8;
    localparam logic [29:0] IDX_TRIG_CTRL  = 30'h05fffee9;
    // Only index bits 27..24 and 8..0 take part in decoding
    localparam logic [29:0] IDX_DEC_MASK   = 30'h0f0001ff;

    // ==========================================================
    // Field positions and reset values
    localparam int unsigned CS_DONE_BIT  = 7;
    localparam int unsigned TRG_EN_BIT   = 7;
    localparam logic [7:0]  CS_RESET     = 8'h00;
    localparam logic [7:0]  TRG_RESET    = 8'h7f;
    localparam logic [6:0]  TRG_RSVD     = 7'h7f;
    localparam logic [5:0]  LOW_RSVD     = 6'h00;

    typedef struct packed {
        logic       done;
        logic       irq_en;
        logic       start;
        logic       scan;
        logic       fast;
        logic [2:0] chan;
    } adcri_csr_s;

    typedef enum logic [0:0] {
        ADCRI_IDLE,
        ADCRI_CONV
    } adcri_state_e;

endpackage

// file: rtl/adcri_top.sv
// Register side and successive-approximation sequencer of an eight-input converter.
// Assumes an external DAC plus comparator: the block drives the trial code and
// reads back one comparator bit from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Upper result byte holds eight MSBs
// - Low byte bits 7..6 LSBs, rest zero
// - Inputs 0-3 group zero, 4-7 group one
// - Input n and n+4 share register
// - Results cleared on reset and standby
// - Results always readable, writes ignored
// - Low byte read from holding latch
// - Done flag only cleared by zero write; code also clears it on a DMA read of a result high byte
// - Decode address bits 27-24, 8-0 only
// - Single mode converts one channel per start
// - Scan mode cycles one to four channels
// - External trigger can start conversion
// - Interrupt raised at each conversion end; code raises it with the done flag, after a single or a whole scan, if enabled
// - Conversion end request activates DMA
// - One channel within 6.7 microseconds; code meets it in fast mode only, slow mode takes twice as long
// - High byte read captures low byte
// - Flag after single, or whole scan
// - Scan runs until start cleared, reset, standby
// - Trigger acts on falling edge
module adcri_top
    import adcri_pkg::*;
(
    input  wire logic                  pclk,            // System clock
    input  wire logic                  presetn,         // Async reset, active low
    input  wire logic                  psel,            // APB select
    input  wire logic                  penable,         // APB access phase
    input  wire logic                  pwrite,          // APB direction
    input  wire logic [31:0]           paddr,           // APB byte address
    input  wire logic [31:0]           pwdata,          // APB write data
    output logic                       pready,          // APB ready
    output logic [31:0]                prdata,          // APB read data
    output logic                       pslverr,         // APB error on unmapped
    input  wire logic                  standby,         // Standby mode request
    input  wire logic                  external_start_input, // Trigger pin
    input  wire logic                  comparator_high, // Input at or above trial code
    input  wire logic                  dma_access,      // Access made by DMA
    output logic [adcri_pkg::RES_BITS-1:0] dac_code,    // Trial code to DAC
    output logic [2:0]                 conv_channel,    // Selected analog input
    output logic                       conv_active,     // Conversion running
    output logic                       conversion_end_irq, // Interrupt request
    output logic                       dma_request      // DMA activation
);
    import adcri_pkg::*;

    // ==========================================================
    // Decode
    function automatic logic idx_hit(input logic [29:0] a, input logic [29:0] b);
        idx_hit = ((a ^ b) & IDX_DEC_MASK) == 30'h0;
    endfunction

    logic [29:0] idx;
    logic        sel_res_high;
    logic        sel_res_low;
    logic [1:0]  sel_reg;
    logic        sel_csr;
    logic        sel_trg;
    logic        mapped;
    logic        acc;
    logic        wr;
    logic        rd;

    assign idx = paddr[31:2];

    always_comb
    begin
        sel_res_high = 1'b0;
        sel_res_low  = 1'b0;
        sel_reg      = 2'd0;
        if (idx_hit(idx, IDX_RES_A_HIGH) || idx_hit(idx, IDX_RES_A_LOW))
        begin
            sel_reg = 2'd0;
            sel_res_high = idx_hit(idx, IDX_RES_A_HIGH);
            sel_res_low  = !sel_res_high;
        end
        else if (idx_hit(idx, IDX_RES_B_HIGH) || idx_hit(idx, IDX_RES_B_LOW))
        begin
            sel_reg = 2'd1;
            sel_res_high = idx_hit(idx, IDX_RES_B_HIGH);
            sel_res_low  = !sel_res_high;
        end
        else if (idx_hit(idx, IDX_RES_C_HIGH) || idx_hit(idx, IDX_RES_C_LOW))
        begin
            sel_reg = 2'd2;
            sel_res_high = idx_hit(idx, IDX_RES_C_HIGH);
            sel_res_low  = !sel_res_high;
        end
        else if (idx_hit(idx, IDX_RES_D_HIGH) || idx_hit(idx, IDX_RES_D_LOW))
        begin
            sel_reg = 2'd3;
            sel_res_high = idx_hit(idx, IDX_RES_D_HIGH);
            sel_res_low  = !sel_res_high;
        end
    end

    assign sel_csr = idx_hit(idx, IDX_CTRL_STAT);
    assign sel_trg = idx_hit(idx, IDX_TRIG_CTRL);
    assign mapped  = sel_res_high | sel_res_low | sel_csr | sel_trg;

    // No wait state: read data is registered in the setup cycle
    assign acc     = psel & penable;
    assign pready  = acc;
    assign pslverr = acc & ~mapped;
    assign wr      = acc & pwrite & mapped;
    assign rd      = acc & ~pwrite & mapped;

    // ==========================================================
    // Pin synchronisers
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic cmp_s1;
    logic cmp_s2;
    logic trg_fall;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trg_s1 <= 1'b1;
            trg_s2 <= 1'b1;
            trg_s3 <= 1'b1;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end
        else
        begin
            trg_s1 <= external_start_input;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
            cmp_s1 <= comparator_high;
            cmp_s2 <= cmp_s1;
        end
    end

    // Third flop only delays; the edge is taken between settled copies
    assign trg_fall = trg_s3 & ~trg_s2;

    // ==========================================================
    // Registers
    adcri_csr_s                csr;
    logic                      trig_en;
    logic                      done_seen;
    logic [RES_BITS-1:0]       result [4];
    logic [7:0]                hold_low;
    adcri_state_e              state;
    logic [STEP_W-1:0]         step_cnt;
    logic [3:0]                bit_idx;
    logic                      conv_end;
    logic                      scan_end;
    logic                      sw_start;
    logic                      hw_start;
    logic                      csr_clear_ok;
    logic                      dma_clear;
    logic                      conv_last;
    logic [2:0]                start_chan;
    logic                      start_scan;
    logic                      start_fast;

    assign sw_start     = wr & sel_csr & pwdata[5] & ~csr.start;
    assign hw_start     = trig_en & trg_fall & ~csr.start;
    assign csr_clear_ok = wr & sel_csr & ~pwdata[CS_DONE_BIT] & done_seen;
    // A DMA read of a result high byte stands in for the software clear
    assign dma_clear    = rd & sel_res_high & dma_access & csr.done;

    // A software start uses the fields written with it, not the old ones
    assign start_chan   = sw_start ? pwdata[2:0] : csr.chan;
    assign start_scan   = sw_start ? pwdata[4] : csr.scan;
    assign start_fast   = sw_start ? pwdata[3] : csr.fast;

    // Scan ends at the top channel of the selected set
    assign scan_end = conv_channel[1:0] == csr.chan[1:0];

    // Trigger control: only the enable bit is stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_en <= TRG_RESET[TRG_EN_BIT];
        else if (standby)
            trig_en <= TRG_RESET[TRG_EN_BIT];
        else if (wr && sel_trg)
            trig_en <= pwdata[TRG_EN_BIT];
    end

    // Control/status register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            csr <= adcri_csr_s'(CS_RESET);
        else if (standby)
            csr <= adcri_csr_s'(CS_RESET);
        else
        begin
            if (wr && sel_csr)
            begin
                csr.irq_en <= pwdata[6];
                csr.start  <= pwdata[5];
                csr.scan   <= pwdata[4];
                csr.fast   <= pwdata[3];
                csr.chan   <= pwdata[2:0];
            end
            if (hw_start)
                csr.start <= 1'b1;
            if (conv_end && !csr.scan)
                csr.start <= 1'b0;
            // Setting the flag wins over a clear in the same cycle
            // Last channel is judged when its result is stored
            if (conv_last)
                csr.done <= 1'b1;
            else if (csr_clear_ok || dma_clear)
                csr.done <= 1'b0;
        end
    end

    // A zero write only clears after software has seen the flag set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_seen <= 1'b0;
        else if (standby || !csr.done)
            done_seen <= 1'b0;
        else if (rd && sel_csr)
            done_seen <= 1'b1;
    end

    // ==========================================================
    // Successive approximation sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ADCRI_IDLE;
            step_cnt     <= '0;
            bit_idx      <= 4'd0;
            dac_code     <= '0;
            conv_channel <= 3'd0;
            conv_end     <= 1'b0;
            conv_last    <= 1'b0;
        end
        else
        begin
            conv_end <= 1'b0;
            conv_last <= 1'b0;
            case (state)
                ADCRI_IDLE:
                begin
                    if (!standby && (sw_start || hw_start))
                    begin
                        state    <= ADCRI_CONV;
                        // Scan begins at the base of the group
                        conv_channel <= start_scan ? {start_chan[2], 2'b00} : start_chan;
                        bit_idx  <= 4'(RES_BITS - 1);
                        dac_code <= RES_BITS'(1) << (RES_BITS - 1);
                        // The first step also covers the two-flop comparator delay
                        step_cnt <= start_fast ? STEP_FAST : STEP_SLOW;
                    end
                end
                ADCRI_CONV:
                begin
                    // A software stop keeps the results already stored
                    if (standby || !csr.start)
                        state <= ADCRI_IDLE;
                    else if (step_cnt != '0)
                        step_cnt <= step_cnt - STEP_W'(1);
                    else
                    begin
                        step_cnt <= csr.fast ? STEP_FAST : STEP_SLOW;
                        // Comparator low: the trial bit overshoots the input, drop it
                        if (!cmp_s2)
                            dac_code[bit_idx] <= 1'b0;
                        if (bit_idx != 4'd0)
                        begin
                            bit_idx <= bit_idx - 4'd1;
                            dac_code[bit_idx - 4'd1] <= 1'b1;
                        end
                        else
                        begin
                            conv_end <= 1'b1;
                            // Judge the scan end now; the channel moves on at this edge
                            conv_last <= !csr.scan || scan_end;
                            bit_idx  <= 4'(RES_BITS - 1);
                            if (!csr.scan)
                                state <= ADCRI_IDLE;
                            else
                            begin
                                dac_code <= RES_BITS'(1) << (RES_BITS - 1);
                                conv_channel <= scan_end ? {csr.chan[2], 2'b00}
                                                         : conv_channel + 3'd1;
                            end
                        end
                    end
                end
                default:
                    state <= ADCRI_IDLE;
            endcase
        end
    end

    assign conv_active = state == ADCRI_CONV;

    // Result store: the last decision is folded in as it is written
    logic [RES_BITS-1:0] final_code;
    logic [1:0]          res_slot;

    assign final_code = {dac_code[RES_BITS-1:1], dac_code[0] & cmp_s2};
    assign res_slot   = conv_channel[1:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                result[i] <= '0;
        end
        else if (standby)
        begin
            for (int i = 0; i < 4; i++)
                result[i] <= '0;
        end
        else if (state == ADCRI_CONV && csr.start && step_cnt == '0 && bit_idx == 4'd0)
            result[res_slot] <= final_code;
    end

    // ==========================================================
    // Read path
    // Holding latch moves only on a high-byte read, so a low-only read
    // may return data of an older conversion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_low <= 8'h00;
        else if (rd && sel_res_high)
            hold_low <= {result[sel_reg][1:0], LOW_RSVD};
    end

    // Read data loads in the setup cycle so the access needs no extra wait
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        if (sel_res_high)
            rd_byte = result[sel_reg][RES_BITS-1:2];
        else if (sel_res_low)
            rd_byte = hold_low;
        else if (sel_csr)
            rd_byte = csr;
        else if (sel_trg)
            rd_byte = {trig_en, TRG_RSVD};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= {24'h00_0000, rd_byte};
    end

    // ==========================================================
    // Requests
    // Both follow the sticky flag, so a request is not lost
    // while the bus or the DMA is busy elsewhere
    assign conversion_end_irq = csr.done & csr.irq_en;
    assign dma_request        = csr.done;

endmodule

`default_nettype wire
